// ==== rtl/pvpt_pkg.sv ====
// Constants and types shared by the parallel video port timing block.
`default_nettype none
package pvpt_pkg;
  // ==========================================================================
  // Register addresses.
  localparam logic [15:0] ADDR_MODE = 16'h4700;
  localparam logic [15:0] ADDR_SRC = 16'h4701;
  localparam logic [15:0] ADDR_RISE_H = 16'h4702;
  localparam logic [15:0] ADDR_RISE_L = 16'h4703;
  localparam logic [15:0] ADDR_FALL_H = 16'h4704;
  localparam logic [15:0] ADDR_FALL_L = 16'h4705;
  localparam logic [15:0] ADDR_CHG_H = 16'h4706;
  localparam logic [15:0] ADDR_CHG_L = 16'h4707;
  localparam logic [15:0] ADDR_POL = 16'h4708;
  localparam logic [15:0] ADDR_TEST = 16'h4709;
  localparam logic [15:0] ADDR_HSST_H = 16'h470A;
  localparam logic [15:0] ADDR_HSST_L = 16'h470B;
  localparam logic [15:0] ADDR_RDCTL = 16'h470C;
  localparam logic [15:0] ADDR_HDR = 16'h470D;
  localparam logic [15:0] ADDR_TRL = 16'h470E;
  localparam logic [15:0] ADDR_BYP = 16'h470F;
  localparam logic [15:0] ADDR_HTS_H = 16'h4710;
  localparam logic [15:0] ADDR_HTS_L = 16'h4711;
  localparam logic [15:0] ADDR_STATUS = 16'h4712;
  // ==========================================================================
  // Reset values.
  localparam logic [7:0] MODE_RST = 8'h04;
  localparam logic [7:0] SRC_RST = 8'h00;
  localparam logic [15:0] RISE_RST = 16'h0002;
  localparam logic [15:0] FALL_RST = 16'h0006;
  localparam logic [15:0] CHG_RST = 16'h0010;
  localparam logic [7:0] POL_RST = 8'h09;
  localparam logic [7:0] TEST_RST = 8'h00;
  localparam logic [15:0] HSST_RST = 16'h0040;
  localparam logic [7:0] RDCTL_RST = 8'h81;
  localparam logic [7:0] HDR_RST = 8'h04;
  localparam logic [7:0] TRL_RST = 8'h00;
  localparam logic [7:0] BYP_RST = 8'h00;
  localparam logic [15:0] HTS_RST = 16'h0000;
  // ==========================================================================
  // Field positions.
  localparam int MODE_VFROMFS = 6;
  localparam int MODE_ORDER = 5;
  localparam int MODE_TOGGLE = 4;
  localparam int MODE_VSTART = 3;
  localparam int MODE_FIELD = 2;
  localparam int MODE_EMBED = 1;
  localparam int POL_DDR = 7;
  localparam int POL_VGATE = 5;
  localparam int POL_HGATE = 4;
  localparam int POL_HREF = 2;
  localparam int POL_VSYNC = 1;
  localparam int POL_PCLK = 0;
  localparam int TEST_SWAP_HI = 6;
  localparam int TEST_SWAP_LO = 4;
  localparam int TEST_W8 = 1;
  localparam int TEST_EN = 0;
  // ==========================================================================
  // Data words on the port.
  localparam logic [9:0] CODE_ONES = 10'h3FF;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] BLANK_80 = 10'h200;
  localparam logic [9:0] BLANK_10 = 10'h040;
  localparam logic [9:0] BLANK_IDLE = 10'h000;
  localparam logic [1:0] CODE_LAST = 2'h3;
  localparam int PIPE_DEPTH = 4;
  // ==========================================================================
  // Types.
  typedef struct packed {
    logic [7:0] mode;
    logic [1:0] src;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] chg;
    logic [7:0] pol;
    logic [7:0] test;
  } pvpt_cfg_t;
  localparam pvpt_cfg_t CFG_RST = '{mode: MODE_RST, src: SRC_RST[1:0],
    rise: RISE_RST, fall: FALL_RST, chg: CHG_RST, pol: POL_RST,
    test: TEST_RST};
  typedef struct packed {
    logic [9:0] data;
    logic href;
    logic fv;
    logic eof;
    logic gpo;
  } pvpt_word_t;
  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_SAV = 2'b01,
    SC_EAV = 2'b10
  } pvpt_sc_t;
  typedef enum logic [1:0] {
    VSRC_EOF0 = 2'b00,
    VSRC_GPO = 2'b01,
    VSRC_LINE = 2'b10,
    VSRC_EOF1 = 2'b11
  } pvpt_vsrc_t;
endpackage
`default_nettype wire

// ==== rtl/pvpt_port.sv ====
// Parallel video output port with embedded sync codes and frame sync timing.
// Notes on behaviour
// - Blanking order bit picks 80,10 or 10,80.
// - Blank words toggle only when toggle bit set.
// - Start select places first vertical-blank code.
// - Field bit in sync codes is fixed.
// - Option: vertical blank bit follows frame sync.
// - Two-bit selector picks frame sync source.
// - Frame sync rises at rise line count.
// - Frame sync falls at fall line count.
// - Edges happen at change pixel position.
// - Invert bits for line valid, sync, clock.
// - Gate bits suppress frame sync, line valid.
// - DDR mode moves data on both edges.
// - Test mode replaces data, width, bit rotate.
`timescale 1ns/1ns
`default_nettype none
module pvpt_port (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic pixel_clock,
  input wire logic [9:0] src_data,
  input wire logic src_href,
  input wire logic src_fv,
  output logic src_take,
  output logic [9:0] vid_data,
  output logic vid_href,
  output logic vid_vsync,
  output logic vid_pclk
);
  import pvpt_pkg::*;

  // ==========================================================================
  // Register file on the control clock.
  logic [7:0] mode_reg, src_reg, pol_reg, test_reg, rdctl_reg;
  logic [7:0] hdr_reg, trl_reg, byp_reg;
  logic [15:0] rise_reg, fall_reg, chg_reg, hsst_reg, hts_reg;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, wr_hit;
  logic dirty_reg, req_reg, ack_s1_reg, ack_s2_reg, busy, load;
  logic vs_s1_reg, vs_s2_reg;
  pvpt_cfg_t snap_reg;

  assign wr_hit = reg_wr && reg_addr >= ADDR_MODE && reg_addr <= ADDR_HTS_L;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= MODE_RST;
      src_reg <= SRC_RST;
      rise_reg <= RISE_RST;
      fall_reg <= FALL_RST;
      chg_reg <= CHG_RST;
      pol_reg <= POL_RST;
      test_reg <= TEST_RST;
      hsst_reg <= HSST_RST;
      rdctl_reg <= RDCTL_RST;
      hdr_reg <= HDR_RST;
      trl_reg <= TRL_RST;
      byp_reg <= BYP_RST;
      hts_reg <= HTS_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_MODE: mode_reg <= reg_wdata;
        ADDR_SRC: src_reg <= reg_wdata;
        ADDR_RISE_H: rise_reg[15:8] <= reg_wdata;
        ADDR_RISE_L: rise_reg[7:0] <= reg_wdata;
        ADDR_FALL_H: fall_reg[15:8] <= reg_wdata;
        ADDR_FALL_L: fall_reg[7:0] <= reg_wdata;
        ADDR_CHG_H: chg_reg[15:8] <= reg_wdata;
        ADDR_CHG_L: chg_reg[7:0] <= reg_wdata;
        ADDR_POL: pol_reg <= reg_wdata;
        ADDR_TEST: test_reg <= reg_wdata;
        ADDR_HSST_H: hsst_reg[15:8] <= reg_wdata;
        ADDR_HSST_L: hsst_reg[7:0] <= reg_wdata;
        ADDR_RDCTL: rdctl_reg <= reg_wdata;
        ADDR_HDR: hdr_reg <= reg_wdata;
        ADDR_TRL: trl_reg <= reg_wdata;
        ADDR_BYP: byp_reg <= reg_wdata;
        ADDR_HTS_H: hts_reg[15:8] <= reg_wdata;
        ADDR_HTS_L: hts_reg[7:0] <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (reg_addr)
      ADDR_MODE: rdata_next = mode_reg;
      ADDR_SRC: rdata_next = src_reg;
      ADDR_RISE_H: rdata_next = rise_reg[15:8];
      ADDR_RISE_L: rdata_next = rise_reg[7:0];
      ADDR_FALL_H: rdata_next = fall_reg[15:8];
      ADDR_FALL_L: rdata_next = fall_reg[7:0];
      ADDR_CHG_H: rdata_next = chg_reg[15:8];
      ADDR_CHG_L: rdata_next = chg_reg[7:0];
      ADDR_POL: rdata_next = pol_reg;
      ADDR_TEST: rdata_next = test_reg;
      ADDR_HSST_H: rdata_next = hsst_reg[15:8];
      ADDR_HSST_L: rdata_next = hsst_reg[7:0];
      ADDR_RDCTL: rdata_next = rdctl_reg;
      ADDR_HDR: rdata_next = hdr_reg;
      ADDR_TRL: rdata_next = trl_reg;
      ADDR_BYP: rdata_next = byp_reg;
      ADDR_HTS_H: rdata_next = hts_reg[15:8];
      ADDR_HTS_L: rdata_next = hts_reg[7:0];
      ADDR_STATUS: rdata_next = {6'h00, vs_s2_reg, busy};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  // ==========================================================================
  // Configuration crossing: snapshot held stable while a toggle request and
  // its acknowledge travel between the domains.  A write in the load cycle
  // keeps the dirty flag set so that it is carried by the next transfer.
  assign busy = req_reg != ack_s2_reg;
  assign load = dirty_reg && !busy;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dirty_reg <= 1'b0;
      req_reg <= 1'b0;
      snap_reg <= CFG_RST;
    end else begin
      dirty_reg <= wr_hit || (dirty_reg && !load);
      if (load) begin
        req_reg <= !req_reg;
        snap_reg <= '{mode: mode_reg, src: src_reg[1:0], rise: rise_reg,
          fall: fall_reg, chg: chg_reg, pol: pol_reg, test: test_reg};
      end
    end
  end

  logic px_rst_s1_reg, px_rstn;
  logic req_s1_reg, req_s2_reg, req_s3_reg;
  logic gpo_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      vs_s1_reg <= 1'b0;
      vs_s2_reg <= 1'b0;
    end else begin
      ack_s1_reg <= req_s3_reg;
      ack_s2_reg <= ack_s1_reg;
      vs_s1_reg <= gpo_reg;
      vs_s2_reg <= vs_s1_reg;
    end
  end

  // ==========================================================================
  // Pixel clock domain: reset release, configuration capture.
  always_ff @(posedge pixel_clock or negedge resetn) begin
    if (!resetn) begin
      px_rst_s1_reg <= 1'b0;
      px_rstn <= 1'b0;
    end else begin
      px_rst_s1_reg <= 1'b1;
      px_rstn <= px_rst_s1_reg;
    end
  end

  pvpt_cfg_t cfg_reg;
  always_ff @(posedge pixel_clock or negedge px_rstn) begin
    if (!px_rstn) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
      cfg_reg <= CFG_RST;
    end else begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      if (req_s2_reg != req_s3_reg) begin
        cfg_reg <= snap_reg;
      end
    end
  end

  logic ddr, emb, toggle, vfs;
  assign ddr = cfg_reg.pol[POL_DDR];
  assign emb = cfg_reg.mode[MODE_EMBED];
  assign toggle = cfg_reg.mode[MODE_TOGGLE];
  assign vfs = cfg_reg.mode[MODE_VFROMFS];

  // ==========================================================================
  // Word pacing and output clock.
  logic phase_reg, take_reg, pclk_reg, step;
  assign step = take_reg;
  always_ff @(posedge pixel_clock or negedge px_rstn) begin
    if (!px_rstn) begin
      phase_reg <= 1'b0;
      take_reg <= 1'b0;
      pclk_reg <= 1'b0;
    end else begin
      phase_reg <= !phase_reg;
      take_reg <= ddr || !phase_reg;
      pclk_reg <= !phase_reg ^ cfg_reg.pol[POL_PCLK];
    end
  end
  assign src_take = take_reg;
  assign vid_pclk = pclk_reg;

  // ==========================================================================
  // Line and pixel counters and the programmable frame sync.
  logic [15:0] line_cnt_reg, pix_cnt_reg;
  pvpt_word_t pipe_reg [PIPE_DEPTH];
  pvpt_word_t o;
  assign o = pipe_reg[PIPE_DEPTH-1];

  always_ff @(posedge pixel_clock or negedge px_rstn) begin
    if (!px_rstn) begin
      line_cnt_reg <= 16'h0000;
      pix_cnt_reg <= 16'h0000;
      gpo_reg <= 1'b0;
    end else if (step) begin
      if (src_fv && !pipe_reg[0].fv) begin
        line_cnt_reg <= 16'h0000;
      end else if (!src_href && pipe_reg[0].href) begin
        line_cnt_reg <= line_cnt_reg + 16'h0001;
      end
      if (src_href && !pipe_reg[0].href) begin
        pix_cnt_reg <= 16'h0000;
      end else if (src_href) begin
        pix_cnt_reg <= pix_cnt_reg + 16'h0001;
      end
      if (line_cnt_reg == cfg_reg.rise && pix_cnt_reg == cfg_reg.chg) begin
        gpo_reg <= 1'b1;
      end else if (line_cnt_reg == cfg_reg.fall &&
          pix_cnt_reg == cfg_reg.chg) begin
        gpo_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pixel_clock or negedge px_rstn) begin
    if (!px_rstn) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_reg[i] <= '0;
      end
    end else if (step) begin
      pipe_reg[0] <= '{data: src_data, href: src_href, fv: src_fv,
        eof: pipe_reg[0].fv && !src_fv, gpo: gpo_reg};
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end

  // ==========================================================================
  // Embedded sync code sequencer.
  function automatic logic [7:0] xy_code(input logic f, input logic v,
      input logic h);
    xy_code = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction

  function automatic logic [9:0] rotl(input logic [9:0] d,
      input logic [2:0] n);
    logic [19:0] w;
    w = {d, d} << n;
    rotl = w[19:10];
  endfunction

  pvpt_sc_t sc_reg;
  logic [1:0] idx_reg;
  logic [7:0] xy_reg, xy_next;
  logic vblank_reg, href_prev_reg, sav_start, eav_start, last_line;
  logic fbit;
  assign fbit = cfg_reg.mode[MODE_FIELD];
  assign eav_start = emb && href_prev_reg && !o.href;
  assign sav_start = emb && !eav_start && src_href && !pipe_reg[0].href;
  assign last_line = !o.fv;

  always_comb begin
    xy_next = xy_reg;
    if (eav_start) begin
      if (vfs) begin
        xy_next = xy_code(fbit, o.gpo, 1'b1);
      end else if (cfg_reg.mode[MODE_VSTART]) begin
        xy_next = xy_code(fbit, last_line, 1'b1);
      end else begin
        xy_next = xy_code(fbit, vblank_reg, 1'b1);
      end
    end else if (sav_start) begin
      xy_next = xy_code(fbit, vfs ? o.gpo : 1'b0, 1'b0);
    end
  end

  always_ff @(posedge pixel_clock or negedge px_rstn) begin
    if (!px_rstn) begin
      sc_reg <= SC_IDLE;
      idx_reg <= 2'h0;
      xy_reg <= 8'h00;
      vblank_reg <= 1'b1;
      href_prev_reg <= 1'b0;
    end else if (step) begin
      href_prev_reg <= o.href;
      xy_reg <= xy_next;
      if (eav_start) begin
        sc_reg <= SC_EAV;
        idx_reg <= 2'h1;
        vblank_reg <= last_line;
      end else if (sav_start) begin
        sc_reg <= SC_SAV;
        idx_reg <= 2'h1;
        vblank_reg <= 1'b0;
      end else begin
        unique case (sc_reg)
          SC_IDLE: idx_reg <= 2'h0;
          SC_SAV, SC_EAV: begin
            idx_reg <= idx_reg + 2'h1;
            if (idx_reg == CODE_LAST) begin
              sc_reg <= SC_IDLE;
            end
          end
          default: sc_reg <= SC_IDLE;
        endcase
      end
    end
  end

  // ==========================================================================
  // Output word, line valid and frame sync.
  logic [9:0] tcnt_reg, data_reg, data_next, pix_word;
  logic blank_ph_reg, href_reg, vsync_reg, code_busy, blank_slot;
  logic vs_raw;
  assign code_busy = sc_reg != SC_IDLE;
  assign blank_slot = !o.href && !eav_start && !sav_start && !code_busy;

  always_comb begin
    if (cfg_reg.test[TEST_EN]) begin
      pix_word = cfg_reg.test[TEST_W8] ? {tcnt_reg[7:0], 2'b00} : tcnt_reg;
    end else begin
      pix_word = o.data;
    end
    pix_word = rotl(pix_word, cfg_reg.test[TEST_SWAP_HI:TEST_SWAP_LO]);
    if (o.href) begin
      data_next = pix_word;
    end else if (eav_start || sav_start) begin
      data_next = CODE_ONES;
    end else if (code_busy) begin
      data_next = idx_reg == CODE_LAST ? {xy_reg, 2'b00} : CODE_ZERO;
    end else if (toggle && o.fv) begin
      data_next = (blank_ph_reg ^ cfg_reg.mode[MODE_ORDER]) ?
        BLANK_10 : BLANK_80;
    end else begin
      data_next = BLANK_IDLE;
    end
    unique case (pvpt_vsrc_t'(cfg_reg.src))
      VSRC_GPO: vs_raw = o.gpo;
      VSRC_LINE: vs_raw = o.href;
      VSRC_EOF0, VSRC_EOF1: vs_raw = o.eof;
    endcase
  end

  always_ff @(posedge pixel_clock or negedge px_rstn) begin
    if (!px_rstn) begin
      tcnt_reg <= 10'h000;
      blank_ph_reg <= 1'b0;
      data_reg <= BLANK_IDLE;
      href_reg <= 1'b0;
      vsync_reg <= 1'b0;
    end else if (step) begin
      tcnt_reg <= o.href ? tcnt_reg + 10'h001 : 10'h000;
      blank_ph_reg <= blank_slot && toggle && o.fv && !blank_ph_reg;
      data_reg <= data_next;
      href_reg <= (o.href && !cfg_reg.pol[POL_HGATE]) ^
        cfg_reg.pol[POL_HREF];
      vsync_reg <= (vs_raw && !cfg_reg.pol[POL_VGATE]) ^
        cfg_reg.pol[POL_VSYNC];
    end
  end
  assign vid_data = data_reg;
  assign vid_href = href_reg;
  assign vid_vsync = vsync_reg;

  // ==========================================================================
  // Checks.
  a_blank_order: assert property (@(posedge pixel_clock) disable iff
    (!px_rstn) step && blank_slot && toggle && o.fv && !blank_ph_reg
    |=> data_reg == ($past(cfg_reg.mode[MODE_ORDER]) ? BLANK_10 :
    BLANK_80))
    else $error("first blanking word has wrong order");
  a_blank_quiet: assert property (@(posedge pixel_clock) disable iff
    (!px_rstn) step && blank_slot && !toggle |=> data_reg == BLANK_IDLE)
    else $error("blanking word toggles while disabled");
  a_vstart_last: assert property (@(posedge pixel_clock) disable iff
    (!px_rstn) step && ddr && eav_start && !vfs && last_line &&
    cfg_reg.mode[MODE_VSTART] |=> ##3 data_reg[7])
    else $error("end code of last line lacks vertical blank");
  a_sav_field: assert property (@(posedge pixel_clock) disable iff
    (!px_rstn) step && ddr && sav_start && $stable(cfg_reg) |=>
    data_reg == CODE_ONES ##1 data_reg == CODE_ZERO ##1
    data_reg == CODE_ZERO ##1 data_reg[8] == $past(fbit, 3))
    else $error("start code sequence or field bit wrong");
  a_vblank_fs: assert property (@(posedge pixel_clock) disable iff
    (!px_rstn) step && eav_start && vfs |=> xy_reg[5] == $past(o.gpo))
    else $error("vertical bit not taken from frame sync");
  a_vsync_src: assert property (@(posedge pixel_clock) disable iff
    (!px_rstn) step && cfg_reg.src == VSRC_LINE && $stable(cfg_reg) &&
    !cfg_reg.pol[POL_VGATE] |=> vid_vsync ==
    ($past(o.href) ^ cfg_reg.pol[POL_VSYNC]))
    else $error("line sync not routed to frame sync");
  a_fs_rise: assert property (@(posedge pixel_clock) disable iff
    (!px_rstn) step && line_cnt_reg == cfg_reg.rise &&
    pix_cnt_reg == cfg_reg.chg |=> gpo_reg)
    else $error("frame sync did not rise");
  a_fs_fall: assert property (@(posedge pixel_clock) disable iff
    (!px_rstn) step && line_cnt_reg == cfg_reg.fall &&
    line_cnt_reg != cfg_reg.rise && pix_cnt_reg == cfg_reg.chg
    |=> !gpo_reg)
    else $error("frame sync did not fall");
  a_href_pol: assert property (@(posedge pixel_clock) disable iff
    (!px_rstn) step && o.href && cfg_reg.pol[POL_HREF] &&
    !cfg_reg.pol[POL_HGATE] && $stable(cfg_reg) |=> !vid_href)
    else $error("inverted line valid not low");
  a_vs_gate: assert property (@(posedge pixel_clock) disable iff
    (!px_rstn) step && cfg_reg.pol[POL_VGATE] && $stable(cfg_reg)
    |=> vid_vsync == cfg_reg.pol[POL_VSYNC])
    else $error("gated frame sync not inactive");
  a_ddr_rate: assert property (@(posedge pixel_clock) disable iff
    (!px_rstn) !ddr && take_reg && $stable(ddr) |=> !take_reg)
    else $error("single rate mode steps every cycle");
  a_test_data: assert property (@(posedge pixel_clock) disable iff
    (!px_rstn) step && o.href && cfg_reg.test[TEST_EN] &&
    !cfg_reg.test[TEST_W8] && cfg_reg.test[TEST_SWAP_HI:TEST_SWAP_LO] == 3'h0
    |=> data_reg == $past(tcnt_reg))
    else $error("test word not driven");
  c_sav: cover property (@(posedge pixel_clock) step && sav_start);
  c_eav_last: cover property (@(posedge pixel_clock) eav_start && last_line);
  c_fs_rise: cover property (@(posedge pixel_clock) $rose(gpo_reg));
  c_test: cover property (@(posedge pixel_clock)
    step && o.href && cfg_reg.test[TEST_EN]);
endmodule
`default_nettype wire

// ==== sim/pvpt_rx_model.sv ====
// Receiver model that samples the video port and tallies what it sees.
`timescale 1ns/1ns
`default_nettype none
module pvpt_rx_model (
  input wire logic pixel_clock,
  input wire logic clear,
  input wire logic [7:0] pol,
  input wire logic [9:0] vid_data,
  input wire logic vid_href,
  input wire logic vid_vsync,
  input wire logic vid_pclk,
  output logic [15:0] cap_cnt,
  output logic [15:0] sum,
  output logic [15:0] vs_cnt,
  output logic [9:0] fb,
  output logic fbit
);
  // ==========================================================================
  // Sampling
  logic pc_q = 1'b0;
  logic eav = 1'b0;
  logic [29:0] hist = 30'h0;
  wire logic code = hist == {10'h3FF, 20'h00000};
  wire logic step = vid_pclk != pc_q && (pol[7] || vid_pclk != pol[0]);
  always @(posedge pixel_clock) begin
    pc_q <= vid_pclk;
    if (clear) begin
      cap_cnt <= 16'h0000;
      sum <= 16'h0000;
      vs_cnt <= 16'h0000;
      eav <= 1'b0;
    end else if (step) begin
      hist <= {hist[19:0], vid_data};
      if (vid_href != pol[2]) begin
        cap_cnt <= cap_cnt + 16'h0001;
        sum <= sum + {6'h00, vid_data};
      end
      if (vid_vsync) begin
        vs_cnt <= vs_cnt + 16'h0001;
      end
      // The latest end-of-line code wins: within one frame that is the code
      // after the last active line, the only one followed by true blanking.
      eav <= code && vid_data[6];
      if (code && vid_data[6]) begin
        fbit <= vid_data[8];
      end
      if (eav) begin
        fb <= vid_data;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking testbench for the parallel video port.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pvpt_pkg::*;
  typedef struct packed {
    logic [7:0] mode, pol, src, tst;
    logic [15:0] cap, sum, vs;
    logic [9:0] fb;
    logic [1:0] f;
  } pvpt_row_t;
  localparam logic [15:0] DC = 16'hFFFF;
  localparam logic [15:0] NZ = 16'hFFFE;
  localparam logic [9:0] NB = 10'h3FF;
  logic clock = 1'b0;
  logic pixel_clock = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] pol = 8'h09;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clear = 1'b1;
  logic took = 1'b0;
  logic [7:0] reg_rdata, rd_val;
  logic reg_rvalid, src_take, vid_href, vid_vsync, vid_pclk, fbit;
  logic [9:0] vid_data, fb;
  logic [15:0] cap_cnt, sum, vs_cnt;
  logic [3:0] pos = 4'h0;
  logic [2:0] line = 3'h0;
  int frame_cnt = 0;
  int n_errors = 0;
  int cmp_count = 0;
  wire logic [9:0] src_data = 10'h020 + {6'h00, pos};
  wire logic src_fv = line < 3'd4;
  wire logic src_href = src_fv && pos < 4'd8;
  logic [15:0] regs [19] = '{16'h0004, 16'h0100, 16'h0200, 16'h0302,
    16'h0400, 16'h0506, 16'h0600, 16'h0710, 16'h0809, 16'h0900, 16'h0A00,
    16'h0B40, 16'h0C81, 16'h0D04, 16'h0E00, 16'h0F00, 16'h1000, 16'h1100,
    16'h1300};
  pvpt_row_t rows [15] = '{
    '{8'h04, 8'h09, 8'h01, 8'h00, 16'd32, 16'd1136, 16'd32, NB, 2'd3},
    '{8'h04, 8'h08, 8'h01, 8'h00, 16'd32, 16'd1136, 16'd32, NB, 2'd3},
    '{8'h04, 8'h0B, 8'h01, 8'h00, 16'd32, 16'd1136, 16'd48, NB, 2'd3},
    '{8'h04, 8'h29, 8'h01, 8'h00, 16'd32, 16'd1136, 16'd0, NB, 2'd3},
    '{8'h04, 8'h19, 8'h01, 8'h00, 16'd0, 16'd0, 16'd32, NB, 2'd3},
    '{8'h04, 8'h09, 8'h00, 8'h00, 16'd32, 16'd1136, 16'd1, NB, 2'd3},
    '{8'h04, 8'h09, 8'h02, 8'h00, 16'd32, 16'd1136, 16'd32, NB, 2'd3},
    '{8'h04, 8'h09, 8'h03, 8'h00, 16'd32, 16'd1136, 16'd1, NB, 2'd3},
    '{8'h04, 8'h09, 8'h01, 8'h01, 16'd32, 16'd112, 16'd32, NB, 2'd3},
    '{8'h04, 8'h09, 8'h01, 8'h03, 16'd32, 16'd448, 16'd32, NB, 2'd3},
    '{8'h04, 8'h09, 8'h01, 8'h11, 16'd32, 16'd224, 16'd32, NB, 2'd3},
    '{8'h06, 8'h09, 8'h01, 8'h00, 16'd32, 16'd1136, 16'd32, 10'h000, 2'd1},
    '{8'h16, 8'h09, 8'h01, 8'h00, 16'd32, 16'd1136, 16'd32, 10'h200, 2'd1},
    '{8'h32, 8'h09, 8'h01, 8'h00, 16'd32, 16'd1136, 16'd32, 10'h040, 2'd0},
    '{8'h4E, 8'h8D, 8'h01, 8'h00, 16'd32, 16'd1136, 16'd32, 10'h000, 2'd1}};
  pvpt_port dut_u (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pixel_clock(pixel_clock), .src_data(src_data), .src_href(src_href),
    .src_fv(src_fv), .src_take(src_take), .vid_data(vid_data),
    .vid_href(vid_href), .vid_vsync(vid_vsync), .vid_pclk(vid_pclk));
  pvpt_rx_model rx_u (.pixel_clock(pixel_clock), .clear(clear), .pol(pol),
    .vid_data(vid_data), .vid_href(vid_href), .vid_vsync(vid_vsync),
    .vid_pclk(vid_pclk), .cap_cnt(cap_cnt), .sum(sum), .vs_cnt(vs_cnt),
    .fb(fb), .fbit(fbit));
  // ==========================================================================
  // Clocks and pixel source
  always #4 clock = ~clock;
  initial begin
    #3;
    forever #40 pixel_clock = ~pixel_clock;
  end
  always @(posedge pixel_clock) took <= src_take;
  // Each line has 8 valid and 8 blank words; line 4 is vertical blank.
  always @(negedge pixel_clock) begin
    if (took) begin
      pos <= pos + 4'd1;
      if (pos == 4'hF) begin
        line <= (line == 3'd4) ? 3'd0 : line + 3'd1;
        frame_cnt <= frame_cnt + int'(line == 3'd4);
      end
    end
  end
  // ==========================================================================
  // Tasks and tests
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = {8'h47, a};
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    reg_addr = {8'h47, a};
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge clock);
    rd_val = reg_rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    if (exp === DC) return;
    cmp_count++;
    if (exp === NZ ? got === 16'h0000 : got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic frames(input int n);
    int f0;
    repeat (n) begin
      f0 = frame_cnt;
      wait (frame_cnt != f0);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clock);
    chk({2'b00, vid_data, vid_href, vid_vsync, vid_pclk, reg_rvalid}, 16'h0);
    resetn = 1'b1;
    #800;
    chk({15'h0000, vid_href}, 16'h0000);
    foreach (regs[i]) begin
      rd(regs[i][15:8]);
      chk({8'h00, rd_val}, {8'h00, regs[i][7:0]});
      wr(regs[i][15:8], regs[i][7:0] ^ 8'h03);
      rd(regs[i][15:8]);
      chk({8'h00, rd_val}, i == 18 ? 16'h0 : {8'h00, regs[i][7:0] ^ 8'h03});
      wr(regs[i][15:8], regs[i][7:0]);
    end
    wr(8'h03, 8'h01);
    wr(8'h05, 8'h03);
    wr(8'h07, 8'h04);
    foreach (rows[i]) begin
      wr(8'h00, rows[i].mode);
      wr(8'h08, rows[i].pol);
      wr(8'h01, rows[i].src);
      wr(8'h09, rows[i].tst);
      pol = rows[i].pol;
      frames(1);
      clear = 1'b1;
      #240;
      clear = 1'b0;
      frames(1);
      // Exactly one frame period lies between clear and the compares.
      #240;
      chk(cap_cnt, rows[i].cap);
      chk(sum, rows[i].sum);
      chk(vs_cnt, rows[i].vs);
      chk({6'h00, fb}, {rows[i].fb == NB ? 6'h3F : 6'h00, rows[i].fb});
      chk({15'h0000, fbit},
        {rows[i].f == 2'd3 ? 14'h3FFF : 14'h0000, rows[i].f});
    end
    // Mid-run reset brings the port and the registers back to idle.
    @(negedge clock);
    resetn = 1'b0;
    repeat (12) @(negedge clock);
    chk({2'b00, vid_data, vid_href, vid_vsync, vid_pclk, reg_rvalid}, 16'h0);
    resetn = 1'b1;
    rd(8'h08);
    chk({8'h00, rd_val}, {8'h00, POL_RST});
    wrap_up();
  end
  initial begin
    #800000;
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
